// ### fcp_consts.svh
`ifndef FCP_CONSTS_SVH
`define FCP_CONSTS_SVH
// Register map, index is address minus one
`define FCP_NUM_REGS      10
`define FCP_ADDR_FIRST    4'h1
`define FCP_ADDR_LAST     4'ha
`define FCP_IDX_LAST      4'h9
`define FCP_ADDR_AE_LO    4'h4
`define FCP_ADDR_AE_HI    4'h5
`define FCP_ADDR_AF_LO    4'h7
`define FCP_ADDR_AF_HI    4'h8
`define FCP_IDX_AE_LO     3
`define FCP_IDX_AE_HI     4
`define FCP_IDX_AF_LO     6
`define FCP_IDX_AF_HI     7
`define FCP_IDX_FAST      9
`define FCP_FAST_BIT      7
// Reset values and writable masks
`define FCP_RST_RSVD      8'h00
`define FCP_RST_OFF_LO    8'h7f
`define FCP_RST_OFF_HI    8'h00
`define FCP_RST_FAST      8'h80
`define FCP_MASK_RSVD     8'h00
`define FCP_MASK_FULL     8'hff
`define FCP_MASK_HI       8'h03
`define FCP_MASK_FAST     8'h80
// Timing
`define FCP_EFFECT_WCLKS  4'h8
`define FCP_FRAME_LAST    4'hb
`define FCP_OFF_MIN       8'h10
`define FCP_CLK_NS        5
`define FCP_HALF_NS       20
`define FCP_HALF_CYC      ((`FCP_HALF_NS + `FCP_CLK_NS - 1) / `FCP_CLK_NS)
// Controller registers, byte addresses
`define FCP_AV_CMD        4'h0
`define FCP_AV_STATUS     4'h4
`define FCP_CMD_ADDR_LSB  8
`define FCP_CMD_KIND_LSB  12
`define FCP_ST_BUSY       0
`define FCP_ST_PRS        1
`define FCP_ST_ERR        2
`define FCP_ST_RDATA_LSB  8
`endif

// ### fcp_pkg.sv
package fcp_pkg;
  typedef logic [7:0] fcp_byte_type;
  typedef logic [3:0] fcp_addr_type;
  typedef logic [9:0] fcp_offset_type;
  typedef enum logic [2:0] {
    FCP_SER_WR, FCP_PAR_WR, FCP_PAR_RD, FCP_FIFO_WR,
    FCP_FIFO_RD, FCP_MRST, FCP_PRST, FCP_RELEASE
  } fcp_kind_type;
  typedef enum logic [1:0] {FCP_IDLE, FCP_SETUP, FCP_HIGH, FCP_LOW} fcp_state_type;
endpackage

// ### fcp_pins_if.sv
`timescale 1ns/10ps
interface fcp_pins_if;
  logic       serial_program_select_n;
  logic       config_load_select_n;
  logic       write_enable_n;
  logic       read_enable_n;
  logic       write_clk;
  logic       read_clk;
  logic       serial_clk;
  logic       serial_in;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       master_reset;
  logic       partial_reset;
  modport device (
    input  serial_program_select_n, config_load_select_n, write_enable_n,
    input  read_enable_n, write_clk, read_clk, serial_clk, serial_in, data_in,
    input  master_reset, partial_reset,
    output data_out
  );
  modport host (
    output serial_program_select_n, config_load_select_n, write_enable_n,
    output read_enable_n, write_clk, read_clk, serial_clk, serial_in, data_in,
    output master_reset, partial_reset,
    input  data_out
  );
endinterface

// ### fcp_device.sv
// How it works
// RULE1: ten eight-bit registers hold flag offsets
// RULE2: select low means serial, high means parallel
// RULE3: serial bit taken on each serial clock rise
// RULE4: serial frame addresses any one register
// RULE5: parallel load low walks addresses one to ten
// RULE6: pointer wraps from tenth back to first
// RULE7: write clock rise stores input in next register
// RULE8: read clock rise shows next register on output
// RULE9: load high turns strobes into memory accesses
// RULE10: readback only on parallel output port
// RULE11: reprogramming allowed any time after master reset
// RULE12: host issues partial reset after changing registers; host only flags the need, pulsing partial reset on a PRST command
// RULE13: host never reads and writes together
// RULE14: new value applies eight write clocks later
// RULE15: empty offset split over addresses four, five
// RULE16: full offset split over addresses seven, eight
// RULE17: address ten bit seven fast clock, rest reserved
// RULE18: host keeps offsets within sixteen to 1023; the host only refuses serial writes of a low offset byte under sixteen
// RULE19: fast clock bit detected, host may override
// RULE20: serial frame is address then data, MSB first
// RULE21: pointers restart on load high or master reset
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/10ps
`include "fcp_consts.svh"
module fcp_device (
  input  wire logic               ref_clk,
  input  wire logic               rst_n,
  fcp_pins_if.device              pins,
  input  wire logic               fast_clk_detect_valid,
  input  wire logic               fast_clk_detected,
  output fcp_pkg::fcp_offset_type almost_empty_offset,
  output fcp_pkg::fcp_offset_type almost_full_offset,
  output logic                    faster_clock,
  output logic                    fifo_write,
  output fcp_pkg::fcp_byte_type   fifo_write_data,
  output logic                    fifo_read,
  output logic                    fifo_partial_reset
);
  import fcp_pkg::*;

  // Reset values and writable bits per entry
  localparam fcp_byte_type RST_VAL [0:9] = '{
    `FCP_RST_RSVD, `FCP_RST_RSVD, `FCP_RST_RSVD, `FCP_RST_OFF_LO, `FCP_RST_OFF_HI,
    `FCP_RST_RSVD, `FCP_RST_OFF_LO, `FCP_RST_OFF_HI, `FCP_RST_RSVD, `FCP_RST_FAST
  };
  localparam fcp_byte_type WR_MASK [0:9] = '{
    `FCP_MASK_RSVD, `FCP_MASK_RSVD, `FCP_MASK_RSVD, `FCP_MASK_FULL, `FCP_MASK_HI,
    `FCP_MASK_RSVD, `FCP_MASK_FULL, `FCP_MASK_HI, `FCP_MASK_RSVD, `FCP_MASK_FAST
  };
  localparam fcp_offset_type RST_OFF  = {RST_VAL[`FCP_IDX_AE_HI][1:0], RST_VAL[`FCP_IDX_AE_LO]};
  localparam logic           RST_FAST = RST_VAL[`FCP_IDX_FAST][`FCP_FAST_BIT];

  fcp_byte_type   cfg_r [0:9];
  logic           wclk_q_r;
  logic           rclk_q_r;
  logic           sclk_q_r;
  logic [11:0]    shift_r;
  logic [3:0]     bit_cnt_r;
  fcp_addr_type   wptr_r;
  fcp_addr_type   rptr_r;
  logic [3:0]     pend_r;
  fcp_byte_type   data_out_r;
  fcp_offset_type ae_eff_r;
  fcp_offset_type af_eff_r;
  logic           fast_eff_r;
  logic           fifo_write_r;
  fcp_byte_type   fifo_write_data_r;
  logic           fifo_read_r;
  logic           prs_r;
  logic           wclk_rise;
  logic           rclk_rise;
  logic           sclk_rise;
  logic           ser_mode;
  logic           par_mode;
  logic           par_wr;
  logic           par_rd;
  logic           ser_wr;
  fcp_addr_type   ser_addr;
  fcp_byte_type   ser_data;
  logic           ser_addr_ok;
  logic           wr_en;
  fcp_addr_type   wr_idx;
  fcp_byte_type   wr_data;
  logic           apply;

  function automatic fcp_addr_type next_ptr(input fcp_addr_type p);
    next_ptr = (p == `FCP_IDX_LAST) ? 4'h0 : p + 4'h1; // see RULE6
  endfunction

  // Pin clocks are synchronous inputs, edges found against last sample
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wclk_q_r <= 1'b0;
      rclk_q_r <= 1'b0;
      sclk_q_r <= 1'b0;
    end
    else
    begin
      wclk_q_r <= pins.write_clk;
      rclk_q_r <= pins.read_clk;
      sclk_q_r <= pins.serial_clk;
    end
  end

  // Mode decode and access strobes
  assign wclk_rise = pins.write_clk & ~wclk_q_r;
  assign rclk_rise = pins.read_clk & ~rclk_q_r;
  assign sclk_rise = pins.serial_clk & ~sclk_q_r;
  assign ser_mode  = ~pins.serial_program_select_n;  // see RULE2
  assign par_mode  = pins.serial_program_select_n & ~pins.config_load_select_n;  // see RULE5
  assign par_wr    = par_mode & ~pins.write_enable_n & pins.read_enable_n & wclk_rise;  // see RULE7
  assign par_rd    = par_mode & pins.write_enable_n & ~pins.read_enable_n & rclk_rise;  // see RULE8

  // Twelfth bit closes a frame: four address bits, eight data bits
  assign ser_wr      = ser_mode & sclk_rise & (bit_cnt_r == `FCP_FRAME_LAST);  // see RULE20
  assign ser_addr    = shift_r[10:7];
  assign ser_data    = {shift_r[6:0], pins.serial_in};
  assign ser_addr_ok = (ser_addr >= `FCP_ADDR_FIRST) && (ser_addr <= `FCP_ADDR_LAST);  // see RULE4

  // One write port; serial and parallel cannot both be active
  assign wr_en   = par_wr | (ser_wr & ser_addr_ok);
  assign wr_idx  = par_wr ? wptr_r : ser_addr - `FCP_ADDR_FIRST;
  assign wr_data = par_wr ? pins.data_in : ser_data;

  // Serial shifter, restarted whenever the select goes high
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_r   <= 12'h000;
      bit_cnt_r <= 4'h0;
    end
    else if (!ser_mode)
    begin
      bit_cnt_r <= 4'h0;
    end
    else if (sclk_rise)
    begin
      shift_r   <= {shift_r[10:0], pins.serial_in};  // see RULE3
      bit_cnt_r <= ser_wr ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  // Parallel pointers; separate so a read walk does not disturb writes
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_r <= 4'h0;
      rptr_r <= 4'h0;
    end
    else if (pins.master_reset || !par_mode)
    begin
      wptr_r <= 4'h0;  // see RULE21
      rptr_r <= 4'h0;
    end
    else
    begin
      if (par_wr)
        wptr_r <= next_ptr(wptr_r);  // see RULE5
      if (par_rd)
        rptr_r <= next_ptr(rptr_r);
    end
  end

  // Register entries; reserved and unused bits never store
  for (genvar i = 0; i < `FCP_NUM_REGS; i++)
  begin : g_cfg
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
      if (!rst_n)
        cfg_r[i] <= RST_VAL[i];  // see RULE1
      else if (pins.master_reset)
        cfg_r[i] <= RST_VAL[i];  // see RULE11
      else if (wr_en && (wr_idx == 4'(i)))
        cfg_r[i] <= wr_data & WR_MASK[i];  // see RULE15
      else if ((i == `FCP_IDX_FAST) && fast_clk_detect_valid)
        cfg_r[i] <= {fast_clk_detected, 7'h00};  // see RULE19
    end
  end

  // Parallel readback, the only way out of the registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      data_out_r <= 8'h00;
    else if (par_rd)
      data_out_r <= cfg_r[rptr_r];  // see RULE10
  end
  assign pins.data_out = data_out_r;

  // Settling counter in write clock edges; a write or a detection restarts it
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      pend_r <= 4'h0;
    else if (pins.master_reset)
      pend_r <= 4'h0;
    else if (wr_en || fast_clk_detect_valid)
      pend_r <= `FCP_EFFECT_WCLKS;  // see RULE14
    else if (wclk_rise && (pend_r != 4'h0))
      pend_r <= pend_r - 4'h1;
  end
  assign apply = wclk_rise & (pend_r == 4'h1) & ~wr_en;

  // Values in force for the flag logic
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ae_eff_r   <= RST_OFF;
      af_eff_r   <= RST_OFF;
      fast_eff_r <= RST_FAST;
    end
    else if (pins.master_reset)
    begin
      ae_eff_r   <= RST_OFF;
      af_eff_r   <= RST_OFF;
      fast_eff_r <= RST_FAST;
    end
    else if (apply)
    begin
      ae_eff_r   <= {cfg_r[`FCP_IDX_AE_HI][1:0], cfg_r[`FCP_IDX_AE_LO]};  // see RULE15
      af_eff_r   <= {cfg_r[`FCP_IDX_AF_HI][1:0], cfg_r[`FCP_IDX_AF_LO]};  // see RULE16
      fast_eff_r <= cfg_r[`FCP_IDX_FAST][`FCP_FAST_BIT];  // see RULE17
    end
  end

  // Load high hands the strobes to the memory side
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fifo_write_r      <= 1'b0;
      fifo_write_data_r <= 8'h00;
      fifo_read_r       <= 1'b0;
      prs_r             <= 1'b0;
    end
    else
    begin
      fifo_write_r <= pins.config_load_select_n & ~pins.write_enable_n & wclk_rise;  // see RULE9
      fifo_read_r  <= pins.config_load_select_n & ~pins.read_enable_n & rclk_rise;  // see RULE9
      prs_r        <= pins.partial_reset;
      if (pins.config_load_select_n && !pins.write_enable_n && wclk_rise)
        fifo_write_data_r <= pins.data_in;
    end
  end

  assign almost_empty_offset = ae_eff_r;
  assign almost_full_offset  = af_eff_r;
  assign faster_clock        = fast_eff_r;
  assign fifo_write          = fifo_write_r;
  assign fifo_write_data     = fifo_write_data_r;
  assign fifo_read           = fifo_read_r;
  assign fifo_partial_reset  = prs_r;
endmodule

// ### fcp_host.sv
`timescale 1ns/10ps
`include "fcp_consts.svh"
module fcp_host (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  fcp_pins_if.host         pins
);
  import fcp_pkg::*;

  localparam logic [2:0] HALF_LAST = 3'(`FCP_HALF_CYC - 1);

  fcp_state_type state_r;
  fcp_kind_type  kind_r;
  fcp_addr_type  addr_r;
  fcp_byte_type  data_r;
  logic [11:0]   shift_r;
  logic [3:0]    bits_left_r;
  logic [2:0]    div_r;
  logic          sen_n_r, ld_n_r, wen_n_r, ren_n_r;
  logic          wclk_r, rclk_r, sclk_r, si_r, mrst_r, prst_r;
  fcp_byte_type  din_r;
  fcp_byte_type  rdata_r;
  logic          prs_need_r;
  logic          err_r;
  logic          rd_ack_r;
  logic [31:0]   readdata_r;
  logic          tick;
  logic          cmd_sel;
  logic          cmd_go;
  logic          refuse;
  fcp_kind_type  new_kind;
  fcp_addr_type  new_addr;
  fcp_byte_type  new_data;

  assign new_kind = fcp_kind_type'(avs_writedata[`FCP_CMD_KIND_LSB +: 3]);
  assign new_addr = avs_writedata[`FCP_CMD_ADDR_LSB +: 4];
  assign new_data = avs_writedata[7:0];
  assign cmd_sel  = avs_write & (avs_address == `FCP_AV_CMD);
  assign cmd_go   = cmd_sel & (state_r == FCP_IDLE);
  // Serially written low offset bytes under the floor are dropped, not sent
  assign refuse   = (new_kind == FCP_SER_WR) & (new_data < `FCP_OFF_MIN) &
                    ((new_addr == `FCP_ADDR_AE_LO) | (new_addr == `FCP_ADDR_AF_LO));  // see RULE18
  assign tick     = (state_r != FCP_IDLE) & (div_r == HALF_LAST);

  // Half-period divider, idle when no command runs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_r <= 3'h0;
    else if (state_r == FCP_IDLE || tick)
      div_r <= 3'h0;
    else
      div_r <= div_r + 3'h1;
  end

  // One operation at a time, so reads and writes never overlap
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= FCP_IDLE;
      kind_r  <= FCP_RELEASE;
      addr_r  <= 4'h0;
      data_r  <= 8'h00;
      shift_r <= 12'h000;
      bits_left_r <= 4'h0;
      {sen_n_r, ld_n_r, wen_n_r, ren_n_r} <= 4'hf;
      {wclk_r, rclk_r, sclk_r, si_r, mrst_r, prst_r} <= 6'h00;
      din_r   <= 8'h00;
      rdata_r <= 8'h00;
    end
    else
    begin
      case (state_r)
        FCP_IDLE:
          if (cmd_go && !refuse)  // see RULE13
          begin
            kind_r  <= new_kind;
            addr_r  <= new_addr;
            data_r  <= new_data;
            state_r <= FCP_SETUP;
            case (new_kind)
              FCP_SER_WR:
              begin
                sen_n_r     <= 1'b0;  // see RULE2
                ld_n_r      <= 1'b1;
                si_r        <= new_addr[3];  // see RULE20
                shift_r     <= {new_addr[2:0], new_data, 1'b0};
                bits_left_r <= `FCP_FRAME_LAST;
              end
              FCP_PAR_WR:  {ld_n_r, wen_n_r, din_r} <= {2'b00, new_data};  // see RULE7
              FCP_PAR_RD:  {ld_n_r, ren_n_r} <= 2'b00;  // see RULE8
              FCP_FIFO_WR: {ld_n_r, wen_n_r, din_r} <= {2'b10, new_data};
              FCP_FIFO_RD: {ld_n_r, ren_n_r} <= 2'b10;
              FCP_MRST:    {ld_n_r, mrst_r} <= 2'b11;
              FCP_PRST:    prst_r <= 1'b1;  // see RULE12
              default:     ld_n_r <= 1'b1;
            endcase
          end
        FCP_SETUP:
          if (tick)
          begin
            state_r <= FCP_HIGH;
            case (kind_r)
              FCP_SER_WR:               sclk_r <= 1'b1;  // see RULE3
              FCP_PAR_WR, FCP_FIFO_WR: wclk_r <= 1'b1;
              FCP_PAR_RD, FCP_FIFO_RD: rclk_r <= 1'b1;
              default:                  sclk_r <= 1'b0;
            endcase
          end
        FCP_HIGH:
          if (tick)
          begin
            {wclk_r, rclk_r, sclk_r} <= 3'b000;
            if (kind_r == FCP_SER_WR && bits_left_r != 4'h0)
            begin
              si_r        <= shift_r[11];
              shift_r     <= {shift_r[10:0], 1'b0};
              bits_left_r <= bits_left_r - 4'h1;
              state_r     <= FCP_SETUP;
            end
            else
            begin
              if (kind_r == FCP_PAR_RD || kind_r == FCP_FIFO_RD)
                rdata_r <= pins.data_out;
              state_r <= FCP_LOW;
            end
          end
        FCP_LOW:
          if (tick)
          begin
            // Load stays low so parallel walks continue across commands
            {sen_n_r, wen_n_r, ren_n_r} <= 3'b111;
            {mrst_r, prst_r} <= 2'b00;
            state_r <= FCP_IDLE;
          end
        default: state_r <= FCP_IDLE;
      endcase
    end
  end

  // Status flags; a refused command sets the error even when cleared together
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prs_need_r <= 1'b0;
      err_r      <= 1'b0;
    end
    else
    begin
      if (state_r == FCP_LOW && tick)
      begin
        if (kind_r == FCP_SER_WR || kind_r == FCP_PAR_WR)
          prs_need_r <= 1'b1;  // see RULE12
        else if (kind_r == FCP_PRST || kind_r == FCP_MRST)
          prs_need_r <= 1'b0;
      end
      if (cmd_go && refuse)
        err_r <= 1'b1;
      else if (avs_write && avs_address == `FCP_AV_STATUS && avs_writedata[`FCP_ST_ERR])
        err_r <= 1'b0;
    end
  end

  // Reads answer one cycle late from a register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_ack_r   <= 1'b0;
      readdata_r <= 32'h0000_0000;
    end
    else
    begin
      rd_ack_r <= avs_read & ~rd_ack_r;
      if (avs_address == `FCP_AV_STATUS)
        readdata_r <= {16'h0000, rdata_r, 5'h00, err_r, prs_need_r, state_r != FCP_IDLE};
      else if (avs_address == `FCP_AV_CMD)
        readdata_r <= {17'h0, kind_r, addr_r, data_r};
      else
        readdata_r <= 32'h0000_0000;
    end
  end

  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = avs_read ? ~rd_ack_r : (cmd_sel & (state_r != FCP_IDLE));

  assign pins.serial_program_select_n = sen_n_r;
  assign pins.config_load_select_n    = ld_n_r;
  assign pins.write_enable_n          = wen_n_r;
  assign pins.read_enable_n           = ren_n_r;
  assign pins.write_clk               = wclk_r;
  assign pins.read_clk                = rclk_r;
  assign pins.serial_clk              = sclk_r;
  assign pins.serial_in               = si_r;
  assign pins.data_in                 = din_r;
  assign pins.master_reset            = mrst_r;
  assign pins.partial_reset           = prst_r;
endmodule

// ### fcp_pins_properties.sv
`timescale 1ns/10ps
module fcp_pins_properties (
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire logic       serial_program_select_n,
  input wire logic       config_load_select_n,
  input wire logic       write_enable_n,
  input wire logic       read_enable_n,
  input wire logic       write_clk,
  input wire logic       read_clk,
  input wire logic       serial_clk,
  input wire logic       serial_in,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       master_reset,
  input wire logic       partial_reset
);
  logic [3:0] sclk_rises_r;

  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Rises within one frame; an idle select clears the count
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      sclk_rises_r <= 4'h0;
    else if (serial_program_select_n)
      sclk_rises_r <= 4'h0;
    else if ($rose(serial_clk))
      sclk_rises_r <= sclk_rises_r + 4'h1;
  end

  // Pin clocks stay high for one half period of four cycles
  sequence s_half_high(sig);
    sig [*4] ##1 !sig;
  endsequence

  // A pin clock rise while the config registers are selected
  sequence s_cfg_rise(clk);
    $rose(clk) ##0 !config_load_select_n;
  endsequence

  a_wclk_half: assert property ($rose(write_clk) |-> s_half_high(write_clk))
    else $error("write clock half period wrong");
  a_rclk_half: assert property ($rose(read_clk) |-> s_half_high(read_clk))
    else $error("read clock half period wrong");
  a_sclk_half: assert property ($rose(serial_clk) |-> s_half_high(serial_clk))
    else $error("serial clock half period wrong");
  a_sclk_in_frame: assert property (serial_clk |-> !serial_program_select_n)
    else $error("serial clock outside a frame");
  a_frame_bits: assert property ($rose(serial_program_select_n) |-> sclk_rises_r == 4'hc)
    else $error("serial frame is not twelve bits");
  a_sin_hold: assert property (serial_clk |-> $stable(serial_in))
    else $error("serial data moved while clock high");
  a_cfg_write: assert property (s_cfg_rise(write_clk) |->
    !write_enable_n && read_enable_n && serial_program_select_n)
    else $error("config write with wrong enables");
  a_cfg_read: assert property (s_cfg_rise(read_clk) |->
    write_enable_n && !read_enable_n && serial_program_select_n)
    else $error("config read with wrong enables");
  a_din_hold: assert property (write_clk |-> $stable(data_in))
    else $error("parallel data moved while clock high");
  a_dout_cause: assert property ($changed(data_out) |->
    ($past(read_clk) && !$past(read_enable_n)) || $past(master_reset))
    else $error("readback changed without a read");
  a_mrst_width: assert property ($rose(master_reset) |-> master_reset [*8])
    else $error("master reset pulse too short");
endmodule

// ### tb_top.sv
`timescale 1ns/10ps
`include "fcp_consts.svh"
module tb_top;
  import fcp_pkg::*;
  typedef struct {logic [31:0] exp; logic [31:0] mask;} fcp_note_type;
  logic           ref_clk;
  logic           rst_n;
  logic [3:0]     avs_address;
  logic           avs_read;
  logic           avs_write;
  logic [31:0]    avs_writedata;
  logic [31:0]    avs_readdata;
  logic           avs_waitrequest;
  logic           fast_clk_detect_valid;
  logic           fast_clk_detected;
  fcp_offset_type almost_empty_offset;
  fcp_offset_type almost_full_offset;
  logic           faster_clock;
  logic           fifo_write;
  fcp_byte_type   fifo_write_data;
  logic           fifo_read;
  logic           fifo_partial_reset;
  fcp_note_type   notes[$], note;
  logic           armed, fast_now;
  int             fails, compares, cyc, fwr_cnt, frd_cnt, prs_cnt, k;
  logic [7:0]     mem [1:10], d;
  logic [9:0]     ae_now, af_now;
  logic [31:0]    rd;

  fcp_pins_if pins ();
  fcp_device u_fcp_device (.ref_clk(ref_clk), .rst_n(rst_n), .pins(pins.device),
    .fast_clk_detect_valid(fast_clk_detect_valid), .fast_clk_detected(fast_clk_detected),
    .almost_empty_offset(almost_empty_offset), .almost_full_offset(almost_full_offset),
    .faster_clock(faster_clock), .fifo_write(fifo_write), .fifo_write_data(fifo_write_data),
    .fifo_read(fifo_read), .fifo_partial_reset(fifo_partial_reset));
  fcp_host u_fcp_host (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pins(pins.host));
  fcp_pins_properties u_fcp_pins_properties (.ref_clk(ref_clk), .rst_n(rst_n),
    .serial_program_select_n(pins.serial_program_select_n),
    .config_load_select_n(pins.config_load_select_n), .write_enable_n(pins.write_enable_n),
    .read_enable_n(pins.read_enable_n), .write_clk(pins.write_clk), .read_clk(pins.read_clk),
    .serial_clk(pins.serial_clk), .serial_in(pins.serial_in), .data_in(pins.data_in),
    .data_out(pins.data_out), .master_reset(pins.master_reset),
    .partial_reset(pins.partial_reset));

  // 200 MHz clock
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  // Writable bits per address; reserved places hold nothing
  function automatic logic [7:0] msk(input int a);
    case (a)
      4, 7: msk = 8'hff;
      5, 8: msk = 8'h03;
      10: msk = 8'h80;
      default: msk = 8'h00;
    endcase
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Avalon cycles hold until waitrequest is seen low at an edge
  task automatic av_wr(input logic [3:0] a, input logic [31:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= 1'b1;
    @(posedge ref_clk iff !avs_waitrequest);
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic av_rd(input logic [3:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge ref_clk iff !avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Queue the expected status, then let the watcher compare it
  task automatic expect_st(input logic [31:0] e, input logic [31:0] m);
    notes.push_back('{e, m});
    armed = 1'b1;
    av_rd(`FCP_AV_STATUS);
    armed = 1'b0;
  endtask

  task automatic cmd(input fcp_kind_type kd, input logic [3:0] a, input logic [7:0] v);
    av_wr(`FCP_AV_CMD, {17'h0, kd, a, v});
    rd = 32'h1;
    while (rd[`FCP_ST_BUSY])
      av_rd(`FCP_AV_STATUS);
  endtask

  task automatic chk_force();
    chk({11'h0, faster_clock, almost_empty_offset, almost_full_offset},
        {11'h0, fast_now, ae_now, af_now});
  endtask

  // Sequential readback from the first register, wrapping after ten
  task automatic read_all(input int n);
    cmd(FCP_RELEASE, 4'h0, 8'h00);
    for (int i = 0; i < n; i++)
    begin
      cmd(FCP_PAR_RD, 4'h0, 8'h00);
      expect_st({16'h0, mem[i % 10 + 1], 8'h00}, 32'h0000ff00);
    end
  endtask

  // Eight write clock rises needed before new values apply
  task automatic settle();
    k = fwr_cnt;
    for (int i = 0; i < 8; i++)
    begin
      cmd(FCP_FIFO_WR, 4'h0, 8'h40 + 8'(i));
      if (i == 6)
        chk_force();
    end
    chk(32'(fwr_cnt - k), 32'h8);
    chk({24'h0, fifo_write_data}, 32'h47);
    ae_now = {mem[5][1:0], mem[4]};
    af_now = {mem[8][1:0], mem[7]};
    fast_now = mem[10][7];
    chk_force();
  endtask

  // Watcher: oldest note against each armed read answer, plus strobe counts
  always @(posedge ref_clk)
  begin
    if (avs_read && !avs_waitrequest && armed && notes.size() > 0)
    begin
      note = notes.pop_front();
      chk(avs_readdata & note.mask, note.exp);
    end
    if (fifo_write === 1'b1)
      fwr_cnt++;
    if (fifo_read === 1'b1)
      frd_cnt++;
    if (fifo_partial_reset === 1'b1)
      prs_cnt++;
  end

  // Hang guard, far above the expected run length
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      finish_test();
    end
  end

  initial
  begin
    void'($urandom(32'h1af8));
    rst_n = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    fast_clk_detect_valid = 1'b0;
    fast_clk_detected = 1'b0;
    armed = 1'b0;
    for (int a = 1; a <= 10; a++)
      mem[a] = (a == 4 || a == 7) ? 8'h7f : ((a == 10) ? 8'h80 : 8'h00);
    ae_now = 10'h07f;
    af_now = 10'h07f;
    fast_now = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk_force();
    read_all(11);
    // Fourteen parallel writes, so the pointer wraps past the tenth
    for (int i = 0; i < 14; i++)
    begin
      d = 8'($urandom) | 8'h10;
      mem[i % 10 + 1] = d & msk(i % 10 + 1);
      cmd(FCP_PAR_WR, 4'h0, d);
    end
    expect_st(32'h2, 32'h2);
    read_all(10);
    settle();
    // Serial frames to every address, plus two out of range
    for (int a = 0; a < 12; a++)
    begin
      d = 8'($urandom) | 8'h10;
      if (a >= 1 && a <= 10)
        mem[a] = d & msk(a);
      cmd(FCP_SER_WR, 4'(a), d);
    end
    read_all(10);
    settle();
    // Too small an offset is refused and flagged
    cmd(FCP_SER_WR, `FCP_ADDR_AE_LO, 8'h05);
    expect_st(32'h4, 32'h4);
    av_wr(`FCP_AV_STATUS, 32'h4);
    expect_st(32'h0, 32'h4);
    read_all(4);
    cmd(FCP_PRST, 4'h0, 8'h00);
    expect_st(32'h0, 32'h2);
    chk({31'h0, prs_cnt != 0}, 32'h1);
    // Detected clock ratio loads the fast bit; toggled so the change shows
    fast_clk_detect_valid <= 1'b1;
    fast_clk_detected <= ~mem[10][7];
    @(posedge ref_clk);
    fast_clk_detect_valid <= 1'b0;
    mem[10] = {~mem[10][7], 7'h00};
    read_all(10);
    settle();
    k = frd_cnt;
    repeat (3) cmd(FCP_FIFO_RD, 4'h0, 8'h00);
    chk(32'(frd_cnt - k), 32'h3);
    // Master reset restores everything; then an unmapped access
    cmd(FCP_MRST, 4'h0, 8'h00);
    for (int a = 1; a <= 10; a++)
      mem[a] = (a == 4 || a == 7) ? 8'h7f : ((a == 10) ? 8'h80 : 8'h00);
    ae_now = 10'h07f;
    af_now = 10'h07f;
    fast_now = 1'b1;
    chk_force();
    read_all(10);
    av_wr(4'hc, 32'hff);
    expect_st(32'h0, 32'h7);
    finish_test();
  end
endmodule
